// >>> common/sda_map.svh
// Overview of operation
// R1 - DMA uses the shared bus only in the second half of a processor cycle.
// R2 - Word address is extended by a 3-bit field selecting one of eight fields.
// R3 - Word address register is a presettable 12-bit binary counter.
// R4 - Processor presets the word address before a transfer sequence begins.
// R5 - Word address increments by one after each transfer; new value is next.
// R6 - Field address register is a presettable 3-bit binary counter.
// R7 - With carry enable set, field and word form one 15-bit counter.
// R8 - Field seven never increments; address wraps inside it and flags error.
// R9 - Top-field wrap requests an interrupt only when status bit eleven set.
// R10 - With carry enable clear, word rollover leaves the field unchanged.
// R11 - Each DMA access presents field and word address on the address lines.
`ifndef SDA_MAP_SVH
`define SDA_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SDA_OFF_WORD 4'h0
`define SDA_OFF_FIELD 4'h4
`define SDA_OFF_STATUS 4'h8
`define SDA_OFF_IRQ_STAT 4'hC
// Interrupt clear and enable share one offset block above status
`define SDA_OFF_IRQ_CLR 5'h10
`define SDA_OFF_IRQ_EN 5'h14
// ****************************************
// Field positions and sizes
// ****************************************
`define SDA_WORD_W 12
`define SDA_FIELD_W 3
`define SDA_BIT_CARRY_EN 9
`define SDA_BIT_INT_PERMIT 11
`define SDA_TOP_FIELD 3'h7
`define SDA_WORD_MAX 12'hFFF
`define SDA_IRQ_WRAP 0
`define SDA_IRQ_XFER 1
`define SDA_IRQ_W 2
`define SDA_STATUS_RST 12'h000
`endif

// >>> common/sda_pkg.sv
package sda_pkg;
  typedef enum logic [1:0] {
    SDA_ACC_READ,
    SDA_ACC_WRITE,
    SDA_ACC_REFRESH
  } sda_acc_e;
  typedef enum logic [1:0] {
    SDA_IDLE,
    SDA_WAIT_SLOT,
    SDA_ACCESS
  } sda_state_e;
endpackage

// >>> logic/sda_counter.sv
`timescale 1ns/1ps
`include "sda_map.svh"
// ****************************************
// Chained word and field address counter
// ****************************************
module sda_counter (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic load_word_i, // Preset word counter
  input wire logic load_field_i, // Preset field counter
  input wire logic [11:0] load_val_i, // Preset value
  input wire logic step_i, // Advance after a transfer
  input wire logic carry_en_i, // Chain field to word
  output logic [11:0] word_o, // Word address
  output logic [2:0] field_o, // Field address
  output logic wrap_o // Top-field wrap pulse
);
  import sda_pkg::*;
  typedef struct packed {
    logic [11:0] word;
    logic [2:0] field;
    logic wrap;
  } sda_cnt_s;
  sda_cnt_s st, next_st;
  logic roll;
  // Next counter state
  always_comb begin
    next_st = st;
    next_st.wrap = 1'b0;
    roll = (st.word == `SDA_WORD_MAX);
    if (step_i) begin
      next_st.word = st.word + 12'h001; // R3 R5
      if (roll && carry_en_i) begin // R7 R10
        if (st.field == `SDA_TOP_FIELD) begin
          next_st.wrap = 1'b1; // R8
        end else begin
          next_st.field = st.field + 3'h1; // R6
        end
      end
    end
    if (load_word_i) begin
      next_st.word = load_val_i; // R3
    end
    if (load_field_i) begin
      next_st.field = load_val_i[2:0]; // R6
    end
  end
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign word_o = st.word;
  assign field_o = st.field;
  assign wrap_o = st.wrap;
  // Assertions
  chk_top_field_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (step_i && !load_field_i && field_o == 3'h7) |=> field_o == 3'h7) // R8
    else $error("top field changed");
  chk_no_carry_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (step_i && !carry_en_i && !load_field_i) |=> $stable(field_o)) // R10
    else $error("field moved without carry");
  chk_carry_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (step_i && carry_en_i && word_o == 12'hFFF && field_o != 3'h7 &&
     !load_field_i) |=> field_o == $past(field_o) + 3'h1) // R7
    else $error("carry not taken");
  chk_word_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    (step_i && !load_word_i) |=> word_o == $past(word_o) + 12'h001) // R5
    else $error("word not incremented");
  chk_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap_o |-> $past(field_o) == 3'h7 && $past(word_o) == 12'hFFF) // R8
    else $error("wrap flagged wrongly");
endmodule

// >>> logic/sda_top.sv
`timescale 1ns/1ps
`include "sda_map.svh"
// ****************************************
// Cycle steal free transfer address engine
// ****************************************
module sda_top (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [4:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic second_half_i, // Second half of processor cycle
  input wire logic dma_req_i, // Transfer request
  input wire sda_pkg::sda_acc_e dma_kind_i, // Read, write or refresh
  output logic mem_sel_o, // Memory access active
  output sda_pkg::sda_acc_e mem_kind_o, // Access kind
  output logic [11:0] mem_addr_o, // Word address lines
  output logic [2:0] mem_field_o, // Extended address lines
  output logic xfer_done_o, // Transfer complete pulse
  output logic irq_o // Interrupt level
);
  import sda_pkg::*;
  typedef struct packed {
    sda_state_e state;
    logic [11:0] status;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] rdata;
    logic ack;
    logic sel;
    sda_acc_e kind;
    logic [11:0] addr;
    logic [2:0] field;
    logic done;
    logic irq;
    logic half;
  } sda_top_s;
  sda_top_s st, next_st;
  logic [11:0] word;
  logic [2:0] field;
  logic wrap;
  logic bus_req;
  logic wr_acc;
  logic ld_word;
  logic ld_field;
  logic step;
  logic [1:0] ev;
  logic [1:0] clr;
  // ****************************************
  // Address counters
  // ****************************************
  sda_counter u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_word_i(ld_word),
    .load_field_i(ld_field),
    .load_val_i(wb_dat_i[11:0]),
    .step_i(step),
    .carry_en_i(st.status[`SDA_BIT_CARRY_EN]),
    .word_o(word),
    .field_o(field),
    .wrap_o(wrap)
  );
  // Bus decode
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    wr_acc = bus_req && wb_we_i;
    ld_word = wr_acc && wb_adr_i == {1'b0, `SDA_OFF_WORD} &&
      wb_sel_i[0] && wb_sel_i[1]; // R4
    ld_field = wr_acc && wb_adr_i == {1'b0, `SDA_OFF_FIELD} && wb_sel_i[0];
    clr = (wr_acc && wb_adr_i == `SDA_OFF_IRQ_CLR && wb_sel_i[0]) ?
      wb_dat_i[1:0] : 2'b00;
    step = (st.state == SDA_ACCESS); // R5
    ev = {step, wrap};
  end
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.ack = bus_req;
    next_st.done = 1'b0;
    next_st.rdata = 32'h00000000;
    next_st.half = second_half_i;
    if (wr_acc) begin
      if (wb_adr_i == {1'b0, `SDA_OFF_STATUS}) begin
        if (wb_sel_i[0]) begin
          next_st.status[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          next_st.status[11:8] = wb_dat_i[11:8];
        end
      end
      if (wb_adr_i == `SDA_OFF_IRQ_EN && wb_sel_i[0]) begin
        next_st.irq_en = wb_dat_i[1:0];
      end
    end
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        {1'b0, `SDA_OFF_WORD}: next_st.rdata = {20'h00000, word};
        {1'b0, `SDA_OFF_FIELD}: next_st.rdata = {29'h0, field};
        {1'b0, `SDA_OFF_STATUS}: next_st.rdata = {20'h00000, st.status};
        {1'b0, `SDA_OFF_IRQ_STAT}: next_st.rdata = {30'h0, st.irq_stat};
        `SDA_OFF_IRQ_EN: next_st.rdata = {30'h0, st.irq_en};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    // Sticky events, set wins over clear
    next_st.irq_stat = (st.irq_stat & ~clr) | ev;
    // Transfer sequencer
    unique case (st.state)
      SDA_IDLE: begin
        next_st.sel = 1'b0;
        if (dma_req_i) begin
          next_st.state = SDA_WAIT_SLOT;
          next_st.kind = dma_kind_i;
        end
      end
      SDA_WAIT_SLOT: begin
        // Start on the first clock of the second half only, so the
        // registered access cycle cannot spill into the next first half
        if (second_half_i && !st.half) begin // R1
          next_st.state = SDA_ACCESS;
          next_st.sel = 1'b1;
          next_st.addr = word; // R11
          next_st.field = field; // R2 R11
        end
      end
      SDA_ACCESS: begin
        next_st.state = SDA_IDLE;
        next_st.sel = 1'b0;
        next_st.done = 1'b1;
      end
    endcase
    // Interrupt output
    next_st.irq = ((next_st.irq_stat[`SDA_IRQ_WRAP] &&
      next_st.irq_en[`SDA_IRQ_WRAP] &&
      st.status[`SDA_BIT_INT_PERMIT]) || // R9
      (next_st.irq_stat[`SDA_IRQ_XFER] && next_st.irq_en[`SDA_IRQ_XFER]));
  end
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign mem_sel_o = st.sel;
  assign mem_kind_o = st.kind;
  assign mem_addr_o = st.addr;
  assign mem_field_o = st.field;
  assign xfer_done_o = st.done;
  assign irq_o = st.irq;
  // ****************************************
  // Assertions
  // ****************************************
  chk_slot_only: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mem_sel_o) |-> $past(second_half_i)) // R1
    else $error("access outside second half");
  chk_addr_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mem_sel_o) |-> mem_addr_o == word && mem_field_o == field) // R11
    else $error("address lines wrong");
  chk_wrap_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_o && !st.irq_en[`SDA_IRQ_XFER]) |->
      $past(st.status[`SDA_BIT_INT_PERMIT])) // R9
    else $error("wrap irq without permit");
  cov_xfer: cover property (@(posedge clk_i) xfer_done_o);
  cov_wrap: cover property (@(posedge clk_i) wrap);
  cov_irq: cover property (@(posedge clk_i) $rose(irq_o));
  // Access cycle stays inside the second half window
  chk_slot_inside: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    mem_sel_o |-> second_half_i)
    else $error("access left the second half");
  // One bus slot per transfer
  chk_sel_single: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    mem_sel_o |=> !mem_sel_o)
    else $error("access longer than one cycle");
  // Completion follows the access
  chk_done_after: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    mem_sel_o |=> xfer_done_o)
    else $error("no completion after access");
  // Counter moves on to the next location
  chk_step_word: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    (mem_sel_o && !ld_word) |=> word == $past(mem_addr_o) + 12'h001)
    else $error("word not advanced after access");
  // Address lines hold outside the slot search
  chk_hold_addr: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    (st.state != SDA_WAIT_SLOT) |=>
      $stable(mem_addr_o) && $stable(mem_field_o))
    else $error("address lines moved");
  // Interrupt only from an enabled event; a wrap event must also be permitted
  chk_irq_gate: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    irq_o |-> (st.irq_stat[`SDA_IRQ_XFER] && st.irq_en[`SDA_IRQ_XFER]) ||
      (st.irq_stat[`SDA_IRQ_WRAP] && st.irq_en[`SDA_IRQ_WRAP] &&
       $past(st.status[`SDA_BIT_INT_PERMIT])))
    else $error("interrupt without enabled event");
  // Wrap event is kept in the status bit
  chk_wrap_sticky: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    wrap |=> st.irq_stat[`SDA_IRQ_WRAP])
    else $error("wrap event lost");
  // Bus answer is a single registered pulse
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered");
  chk_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  cov_carry: cover property (@(posedge clk_i)
    step && word == `SDA_WORD_MAX && st.status[`SDA_BIT_CARRY_EN]);
  cov_refresh: cover property (@(posedge clk_i)
    mem_sel_o && mem_kind_o == SDA_ACC_REFRESH);
endmodule

// >>> tb/sda_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// Shared bus model: cycle phase and memory
// ****************************************
module sda_mem_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic mem_sel_i, // Access strobe
  input wire sda_pkg::sda_acc_e mem_kind_i, // Access kind
  input wire logic [11:0] mem_addr_i, // Word address
  input wire logic [2:0] mem_field_i, // Field address
  output logic second_half_o, // Second half of cycle
  output logic [14:0] seen_addr_o, // Last access address
  output logic [1:0] seen_kind_o // Last access kind
);
  logic [1:0] phase;
  // Four-clock processor cycle, second half is the upper two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign second_half_o = phase[1];
  // Memory latches the address of each access
  always_ff @(posedge clk_i) begin
    if (mem_sel_i) begin
      seen_addr_o <= {mem_field_i, mem_addr_i};
      seen_kind_o <= mem_kind_i;
    end
  end
endmodule

// >>> tb/sda_top_tb.sv
`timescale 1ns/1ps
module sda_top_tb;
  import sda_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, req = 0;
  logic [4:0] adr = 0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 0, q;
  sda_acc_e kind = SDA_ACC_READ;
  logic [31:0] rdat;
  logic ack, half, msel, done, irq;
  sda_acc_e mkind;
  logic [11:0] maddr;
  logic [2:0] mfield;
  logic [14:0] seen;
  logic [1:0] seen_kind;
  integer errors = 0, samples_checked = 0, cycles = 0;
  // Clock and timeout
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  sda_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .second_half_i(half), .dma_req_i(req), .dma_kind_i(kind),
    .mem_sel_o(msel), .mem_kind_o(mkind), .mem_addr_o(maddr),
    .mem_field_o(mfield), .xfer_done_o(done), .irq_o(irq));
  sda_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .mem_sel_i(msel),
    .mem_kind_i(mkind), .mem_addr_i(maddr), .mem_field_i(mfield),
    .second_half_o(half), .seen_addr_o(seen), .seen_kind_o(seen_kind));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d);
    integer n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (ack !== 1'b1) chk("ack", 1, 0);
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input string n);
    wb(0, a, 0);
    chk(n, e, q);
  endtask
  // One DMA transfer; check the address that memory saw
  task automatic xfer(input sda_acc_e k, input logic [14:0] ea);
    integer n;
    n = 0;
    req <= 1;
    kind <= k;
    // Request stands one edge; the idle sequencer takes it there
    @(posedge clk_i);
    req <= 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (done !== 1'b1) chk("dma done", 1, 0);
    @(posedge clk_i);
    chk("dma addr", {17'h0, ea}, {17'h0, seen});
    chk("dma kind", {30'h0, k}, {30'h0, seen_kind});
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(5'h00, 32'h0, "word rst");
    rd(5'h04, 32'h0, "field rst");
    rd(5'h0C, 32'h0, "irq rst");
    wb(1, 5'h00, 32'h123);
    wb(1, 5'h04, 32'h2);
    rd(5'h00, 32'h123, "word");
    rd(5'h04, 32'h2, "field");
    rd(5'h18, 32'h0, "unmapped");
    for (int k = 0; k < 3; k++) begin
      xfer(sda_acc_e'(k), 15'h2123 + 15'(k));
    end
    rd(5'h00, 32'h126, "word step");
    // Carry clear: rollover keeps the field
    wb(1, 5'h00, 32'hFFF);
    xfer(SDA_ACC_WRITE, 15'h2FFF);
    rd(5'h00, 32'h0, "roll word");
    // Word write without both low byte lanes is refused
    sel <= 4'h1;
    wb(1, 5'h00, 32'h456);
    sel <= 4'hF;
    rd(5'h00, 32'h0, "word sel");
    rd(5'h04, 32'h2, "roll field");
    rd(5'h0C, 32'h2, "no wrap");
    // Carry set: one 15-bit counter
    wb(1, 5'h08, 32'h200);
    wb(1, 5'h00, 32'hFFF);
    xfer(SDA_ACC_READ, 15'h2FFF);
    rd(5'h04, 32'h3, "carry field");
    xfer(SDA_ACC_REFRESH, 15'h3000);
    // Top field wraps and flags, interrupt gated
    wb(1, 5'h14, 32'h1);
    wb(1, 5'h10, 32'h3);
    wb(1, 5'h04, 32'h7);
    wb(1, 5'h00, 32'hFFF);
    xfer(SDA_ACC_READ, 15'h7FFF);
    rd(5'h04, 32'h7, "top field");
    rd(5'h00, 32'h0, "top word");
    rd(5'h0C, 32'h3, "wrap flag");
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1, 5'h08, 32'hA00);
    @(posedge clk_i);
    chk("irq on", 32'h1, {31'h0, irq});
    wb(1, 5'h10, 32'h3);
    @(posedge clk_i);
    rd(5'h0C, 32'h0, "irq clr");
    chk("irq off", 32'h0, {31'h0, irq});
    end_of_test();
  end
endmodule
